// file: spf_defines.svh
// register map, field positions, reset values and timing for the self-programming control
//
// Notes on behaviour
// - page-write bit clears itself on completion or after four idle cycles.
// - core is stalled for a whole erase or write aimed at the no-RWW section.
// - erase bit plus enable makes the next store within four cycles erase a page.
// - page-erase bit clears itself on completion or after four idle cycles.
// - the enable bit allows a store only in the four cycles after arming.
// - enable alone makes the next store load the data pair into the page buffer.
// - buffer fill ignores pointer bit zero, so the pointer addresses words.
// - the enable bit clears itself after a store or after four idle cycles.
// - during erase or write the enable bit stays high until the array finishes.
// - only five-bit patterns 10001, 01001, 00101, 00011, 00001 are accepted.
// - six lock bits, one when unprogrammed, zero when programmed, default one.
// - only chip erase or reset returns lock bits to one; nothing else can.
// - without a boot section, stores are allowed only when the fuse reads zero.
// - memory lock 11 free; 10 blocks external programming and locks the fuses.
// - memory lock 00 also blocks external verify and freezes boot lock bits.
// - application lock pair decodes write block and boot-side read block.
// - boot lock pair decodes write block and application-side read block.
// - application read block with vectors in boot hides interrupts in application.
// - boot read block with vectors in application hides interrupts in boot.
// - write bit plus enable makes the next store write the buffer to a page.
// - lock-set bit plus enable makes the next store program locks from data.
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

`define SPF_CTRL_OFFS 12'h000
`define SPF_LOCK_OFFS 12'h004
`define SPF_STAT_OFFS 12'h008

`define SPF_CTRL_RST 5'h00
`define SPF_LOCK_RST 6'h3F

`define SPF_PAT_RRE 5'h11
`define SPF_PAT_LKS 5'h09
`define SPF_PAT_WRT 5'h05
`define SPF_PAT_ERS 5'h03
`define SPF_PAT_FILL 5'h01

`define SPF_SPE_BIT 0
`define SPF_MEM_LO 0
`define SPF_MEM_HI 1
`define SPF_APP_LO 2
`define SPF_APP_HI 3
`define SPF_BOOT_LO 4
`define SPF_BOOT_HI 5

`define SPF_WINDOW_CYCLES 3'h4

`endif

// file: spf_pkg.sv
// types shared by the self-programming control
`default_nettype none
package spf_pkg;
    typedef enum logic [1:0] {SPF_IDLE, SPF_ARMED, SPF_BUSY} spf_state_t;
    typedef logic [15:0] spf_word_t;
    typedef logic [31:0] spf_bus_t;
endpackage
`default_nettype wire

// file: spf_ctrl.sv
// self-programming command sequencer with lock-bit protection and apb registers
`default_nettype none
`include "spf_defines.svh"

module spf_ctrl #(
    parameter int PAGE_WORD_BITS = 6,
    parameter int PAGE_BITS = 8,
    parameter logic [7:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hE0,
    parameter bit HAS_BOOT_SECT = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire spf_pkg::spf_bus_t pwdata,
    output var spf_pkg::spf_bus_t prdata,
    output var logic pready,
    output var logic pslverr,
    // core side
    input wire logic spm_strobe,
    input wire spf_pkg::spf_word_t spm_zptr,
    input wire spf_pkg::spf_word_t spm_data,
    input wire spf_pkg::spf_word_t lpm_zptr,
    input wire logic exec_in_boot,
    input wire logic vec_in_boot,
    output var logic cpu_stall,
    output var logic lpm_allowed,
    output var logic irq_suppress,
    // configuration
    input wire logic self_prog_fuse,
    input wire logic [PAGE_BITS-1:0] boot_first_page,
    input wire logic chip_erase,
    // flash array
    input wire logic fl_done,
    output var logic fl_buf_we,
    output var logic [PAGE_WORD_BITS-1:0] fl_buf_word,
    output var spf_pkg::spf_word_t fl_buf_data,
    output var logic fl_erase,
    output var logic fl_write,
    output var logic [PAGE_BITS-1:0] fl_page,
    // external programming protection
    output var logic ext_prog_block,
    output var logic ext_verify_block,
    output var logic fuse_lock,
    output var logic boot_lock_frozen
);
    import spf_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // accepted command patterns of the low control bits
    function automatic logic pat_valid(input logic [4:0] p);
        return (p == `SPF_PAT_RRE) || (p == `SPF_PAT_LKS) ||
               (p == `SPF_PAT_WRT) || (p == `SPF_PAT_ERS) ||
               (p == `SPF_PAT_FILL);
    endfunction

    // page belongs to the boot section
    function automatic logic in_boot(input logic [PAGE_BITS-1:0] pg,
                                     input logic [PAGE_BITS-1:0] first);
        return HAS_BOOT_SECT && (pg >= first);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spf_state_t st_q, st_d;
    logic [4:0] ctrl_q, ctrl_d;
    logic [2:0] win_q, win_d;
    logic rwwb_q, rwwb_d;
    logic [5:0] lock_q, lock_d;
    logic stall_q, stall_d;
    logic we_d, ers_d, wrt_d;
    spf_bus_t rdata_q;
    logic ready_q, err_q;
    logic [PAGE_WORD_BITS-1:0] word_q;
    spf_word_t data_q;
    logic [PAGE_BITS-1:0] page_q;
    logic we_q, ers_q, wrt_q;
    logic lpm_ok_q, irq_sup_q;
    logic prog_blk_q, ver_blk_q, fuse_lk_q, blb_lk_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------

    // access phase completes with our ready
    wire apb_acc = psel && penable && ready_q;
    wire apb_setup = psel && !penable;
    wire hit_ctrl = (paddr == `SPF_CTRL_OFFS);
    wire hit_lock = (paddr == `SPF_LOCK_OFFS);
    wire hit_stat = (paddr == `SPF_STAT_OFFS);
    wire hit_any = hit_ctrl || hit_lock || hit_stat;
    wire ctrl_wr = apb_acc && pwrite && hit_ctrl;
    wire [4:0] wpat = pwdata[4:0];
    wire arm_ok = ctrl_wr && pat_valid(wpat) && (st_q != SPF_BUSY);

    // read selection
    wire [31:0] rd_ctrl = {24'h000000, 1'b0, rwwb_q, 1'b0, ctrl_q};
    wire [31:0] rd_lock = {24'h000000, 2'b11, lock_q};
    wire [31:0] rd_stat = {28'h0000000, blb_lk_q, fuse_lk_q, stall_q, st_q == SPF_BUSY};
    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_lock ? rd_lock :
                         hit_stat ? rd_stat : 32'h00000000;

    // ------------------------------------------------------------
    // pointer and lock decode
    // ------------------------------------------------------------

    // pointer bit zero is dropped for word addressing
    wire [PAGE_WORD_BITS-1:0] zword = spm_zptr[PAGE_WORD_BITS:1];
    wire [PAGE_BITS-1:0] zpage = spm_zptr[PAGE_WORD_BITS+PAGE_BITS:PAGE_WORD_BITS+1];
    wire [PAGE_BITS-1:0] lpage = lpm_zptr[PAGE_WORD_BITS+PAGE_BITS:PAGE_WORD_BITS+1];
    wire tgt_boot = in_boot(zpage, boot_first_page);
    wire lpm_boot = in_boot(lpage, boot_first_page);

    // write block when low bit programmed, read block when high bit programmed
    wire app_wr_blk = !lock_q[`SPF_APP_LO];
    wire app_rd_blk = !lock_q[`SPF_APP_HI];
    wire boot_wr_blk = !lock_q[`SPF_BOOT_LO];
    wire boot_rd_blk = !lock_q[`SPF_BOOT_HI];
    wire tgt_blk = tgt_boot ? boot_wr_blk : app_wr_blk;

    // small variant: the fuse alone gates every store
    wire spm_off = !HAS_BOOT_SECT && self_prog_fuse;
    wire spm_hit = spm_strobe && (st_q == SPF_ARMED) && !spm_off;
    wire tgt_no_read_while_write_section = zpage >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;

    // memory lock pair decode
    wire [1:0] mem_lk = {lock_q[`SPF_MEM_HI], lock_q[`SPF_MEM_LO]};
    wire prog_blk_d = mem_lk != 2'b11;
    wire ver_blk_d = mem_lk == 2'b00;

    // protected reads and interrupt hiding
    wire lpm_ok_d = !(exec_in_boot && !lpm_boot && app_rd_blk) &&
                    !(!exec_in_boot && lpm_boot && boot_rd_blk);
    wire irq_sup_d = (app_rd_blk && vec_in_boot && !exec_in_boot) ||
                     (boot_rd_blk && !vec_in_boot && exec_in_boot);

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------

    // next state of command bits, window, busy flags and locks
    always_comb
    begin
        st_d = st_q;
        ctrl_d = ctrl_q;
        win_d = win_q;
        rwwb_d = rwwb_q;
        lock_d = lock_q;
        stall_d = stall_q;
        we_d = 1'b0;
        ers_d = 1'b0;
        wrt_d = 1'b0;
        case (st_q)
            SPF_IDLE:
            begin
                if (arm_ok)
                begin
                    ctrl_d = wpat;
                    win_d = `SPF_WINDOW_CYCLES;
                    st_d = SPF_ARMED;
                end
            end
            SPF_ARMED:
            begin
                if (spm_hit)
                begin
                    ctrl_d = `SPF_CTRL_RST;
                    st_d = SPF_IDLE;
                    case (ctrl_q)
                        `SPF_PAT_FILL:
                        begin
                            we_d = 1'b1;
                            rwwb_d = 1'b0;
                        end
                        `SPF_PAT_ERS, `SPF_PAT_WRT:
                        begin
                            // blocked target: disarm with no array action
                            if (!tgt_blk)
                            begin
                                ctrl_d = ctrl_q;
                                ers_d = ctrl_q == `SPF_PAT_ERS;
                                wrt_d = ctrl_q == `SPF_PAT_WRT;
                                stall_d = tgt_no_read_while_write_section;
                                rwwb_d = rwwb_q || !tgt_no_read_while_write_section;
                                st_d = SPF_BUSY;
                            end
                        end
                        `SPF_PAT_LKS:
                        begin
                            // bits can only move toward programmed
                            lock_d = lock_q & spm_data[5:0];
                        end
                        `SPF_PAT_RRE:
                        begin
                            rwwb_d = 1'b0;
                        end
                        default:
                        begin
                            ctrl_d = `SPF_CTRL_RST;
                        end
                    endcase
                end
                else if (win_q <= 3'h1)
                begin
                    ctrl_d = `SPF_CTRL_RST;
                    win_d = 3'h0;
                    st_d = SPF_IDLE;
                end
                else
                begin
                    win_d = win_q - 3'h1;
                end
            end
            SPF_BUSY:
            begin
                if (fl_done)
                begin
                    ctrl_d = `SPF_CTRL_RST;
                    stall_d = 1'b0;
                    win_d = 3'h0;
                    st_d = SPF_IDLE;
                end
            end
            default:
            begin
                st_d = SPF_IDLE;
                ctrl_d = `SPF_CTRL_RST;
            end
        endcase
        if (chip_erase)
        begin
            lock_d = `SPF_LOCK_RST;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // sequencer state
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_q <= SPF_IDLE;
            ctrl_q <= `SPF_CTRL_RST;
            win_q <= 3'h0;
            rwwb_q <= 1'b0;
            lock_q <= `SPF_LOCK_RST;
            stall_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            win_q <= win_d;
            rwwb_q <= rwwb_d;
            lock_q <= lock_d;
            stall_q <= stall_d;
        end
    end

    // flash strobes and their operands
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            we_q <= 1'b0;
            ers_q <= 1'b0;
            wrt_q <= 1'b0;
            word_q <= '0;
            data_q <= 16'h0000;
            page_q <= '0;
        end
        else
        begin
            we_q <= we_d;
            ers_q <= ers_d;
            wrt_q <= wrt_d;
            word_q <= zword;
            data_q <= spm_data;
            page_q <= zpage;
        end
    end

    // protection outputs
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            lpm_ok_q <= 1'b1;
            irq_sup_q <= 1'b0;
            prog_blk_q <= 1'b0;
            ver_blk_q <= 1'b0;
            fuse_lk_q <= 1'b0;
            blb_lk_q <= 1'b0;
        end
        else
        begin
            lpm_ok_q <= lpm_ok_d;
            irq_sup_q <= irq_sup_d;
            prog_blk_q <= prog_blk_d;
            ver_blk_q <= ver_blk_d;
            fuse_lk_q <= prog_blk_d;
            blb_lk_q <= ver_blk_d;
        end
    end

    // apb answer: ready one cycle after setup, error on unmapped
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ready_q <= apb_setup;
            err_q <= apb_setup && !hit_any;
            rdata_q <= apb_setup ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign cpu_stall = stall_q;
    assign lpm_allowed = lpm_ok_q;
    assign irq_suppress = irq_sup_q;
    assign fl_buf_we = we_q;
    assign fl_buf_word = word_q;
    assign fl_buf_data = data_q;
    assign fl_erase = ers_q;
    assign fl_write = wrt_q;
    assign fl_page = page_q;
    assign ext_prog_block = prog_blk_q;
    assign ext_verify_block = ver_blk_q;
    assign fuse_lock = fuse_lk_q;
    assign boot_lock_frozen = blb_lk_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    win_expire_a: assert property (
        st_q == SPF_ARMED && !spm_strobe ##1 !spm_strobe ##1 !spm_strobe
        ##1 !spm_strobe && st_q == SPF_ARMED |=> st_q == SPF_IDLE && ctrl_q == 5'h00)
        else $error("armed window outlived four cycles");

    fill_data_a: assert property (
        spm_hit && ctrl_q == `SPF_PAT_FILL |=> fl_buf_we && fl_buf_data == $past(spm_data))
        else $error("buffer fill lost its data");

    fill_word_a: assert property (
        fl_buf_we |-> fl_buf_word == $past(spm_zptr[PAGE_WORD_BITS:1]))
        else $error("fill word not taken from pointer bits above zero");

    busy_hold_a: assert property (
        st_q == SPF_BUSY && !fl_done |=> ctrl_q[`SPF_SPE_BIT])
        else $error("enable dropped during array operation");

    stall_no_read_while_write_section_a: assert property (
        (fl_erase || fl_write) && fl_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> cpu_stall
        until_with fl_done)
        else $error("core not stalled for no-rww operation");

    lock_mono_a: assert property (
        !$past(chip_erase) |-> (lock_q & ~$past(lock_q)) == 6'h00)
        else $error("lock bit erased without chip erase");

    bad_pattern_a: assert property (
        ctrl_wr && !pat_valid(wpat) && st_q == SPF_IDLE |=> st_q == SPF_IDLE
        && ctrl_q == $past(ctrl_q))
        else $error("invalid control pattern took effect");

    locked_tgt_a: assert property (
        spm_hit && (ctrl_q == `SPF_PAT_ERS || ctrl_q == `SPF_PAT_WRT) && tgt_blk
        |=> !fl_erase && !fl_write && ctrl_q == 5'h00)
        else $error("blocked target was programmed or left armed");

    irq_app_a: assert property (
        app_rd_blk && vec_in_boot && !exec_in_boot |=> irq_suppress)
        else $error("interrupts not hidden in application code");

    mem_lock_a: assert property (
        mem_lk == 2'b00 && $stable(lock_q) |=> ext_verify_block && boot_lock_frozen)
        else $error("full memory lock not enforced");
endmodule
`default_nettype wire

// file: spf_flash_model.sv
// flash array model that answers erase and write starts with a done pulse
`default_nettype none
module spf_flash_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // array control
    input wire logic fl_erase,
    input wire logic fl_write,
    input wire logic [7:0] busy_cycles,
    output var logic fl_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    // ---------------------------------------------
    // busy timer
    // ---------------------------------------------
    // the array stays busy for busy_cycles, then pulses done once
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cnt_q <= 8'h00;
            fl_done <= 1'h0;
        end
        else
        begin
            fl_done <= (cnt_q == 8'h01);
            if (fl_erase || fl_write)
                cnt_q <= busy_cycles;
            else if (cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: spf_ctrl_tb_top.sv
// self-checking bench for the self-programming control
`default_nettype none
`include "spf_defines.svh"
module spf_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spf_pkg::*;
    logic sys_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic spm_strobe = 1'h0, exec_in_boot = 1'h0, vec_in_boot = 1'h0, chip_erase = 1'h0;
    logic self_prog_fuse = 1'h0, pready, pslverr, cpu_stall, lpm_allowed, irq_suppress;
    logic fl_done, fl_buf_we, fl_erase, fl_write, ext_prog_block, ext_verify_block;
    logic fuse_lock, boot_lock_frozen, nb, sm_we;
    logic [11:0] paddr = 12'h000;
    spf_bus_t pwdata = 32'h0, prdata;
    spf_word_t spm_zptr = 16'h0, spm_data = 16'h0, lpm_zptr = 16'h0, fl_buf_data;
    logic [5:0] fl_buf_word;
    logic [7:0] fl_page, boot_first_page = 8'hC0, busy_cycles = 8'h06;
    logic [64:0] a;
    logic [21:0] b;
    logic [9:0] o;
    logic [4:0] bad[5] = '{5'h02, 5'h07, 5'h1F, 5'h10, 5'h0D};
    int fail_count = 0, checked = 0;
    logic [64:0] apb_q[$];
    logic [21:0] buf_q[$];
    logic [9:0] op_q[$];

    // clock
    always #50 sys_clk = ~sys_clk;

    spf_ctrl spf_ctrl_inst (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .spm_strobe, .spm_zptr, .spm_data, .lpm_zptr,
        .exec_in_boot, .vec_in_boot, .cpu_stall, .lpm_allowed, .irq_suppress,
        .self_prog_fuse, .boot_first_page, .chip_erase, .fl_done, .fl_buf_we,
        .fl_buf_word, .fl_buf_data, .fl_erase, .fl_write, .fl_page, .ext_prog_block,
        .ext_verify_block, .fuse_lock, .boot_lock_frozen);
    spf_flash_model spf_flash_model_inst (.sys_clk, .nrst, .fl_erase, .fl_write,
        .busy_cycles, .fl_done);
    // variant without a boot section: only its buffer strobe is watched
    spf_ctrl #(.HAS_BOOT_SECT(1'b0)) spf_ctrl_small_inst (.sys_clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .spm_strobe, .spm_zptr,
        .spm_data, .lpm_zptr, .exec_in_boot, .vec_in_boot, .cpu_stall(), .lpm_allowed(),
        .irq_suppress(), .self_prog_fuse, .boot_first_page, .chip_erase, .fl_done,
        .fl_buf_we(sm_we), .fl_buf_word(), .fl_buf_data(), .fl_erase(), .fl_write(),
        .fl_page(), .ext_prog_block(), .ext_verify_block(), .fuse_lock(),
        .boot_lock_frozen());

    // ---------------------------------------------
    // compare and closing tasks
    // ---------------------------------------------
    task automatic cmp_note(input string what, input logic none, input logic [32:0] exp,
            input logic [32:0] got);
        checked++;
        if (none || got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_lvl(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (apb_q.size() + buf_q.size() + op_q.size() != 0)
            fail_count++;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ---------------------------------------------
    // drivers
    // ---------------------------------------------
    task automatic apb(input logic w, input logic [11:0] ad, input spf_bus_t d,
            input spf_bus_t m, input logic e);
        apb_q.push_back({m, e, d & m});
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do
            @(posedge sys_clk);
        while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] ad, input spf_bus_t d);
        apb(1'h1, ad, d, 32'h0, 1'h0);
    endtask
    task automatic rd(input logic [11:0] ad, input spf_bus_t m, input spf_bus_t e);
        apb(1'h0, ad, e, m, 1'h0);
    endtask
    // a store instruction seen at the k-th edge after the arming write
    task automatic store_program_memory_instr(input int k, input spf_word_t z, input spf_word_t d);
        repeat (k - 1) @(posedge sys_clk);
        spm_strobe <= 1'h1;
        spm_zptr <= z;
        spm_data <= d;
        @(posedge sys_clk);
        spm_strobe <= 1'h0;
        spm_data <= ~d;
    endtask
    task automatic cmd(input logic [4:0] p, input int k, input logic [7:0] pg);
        wr(`SPF_CTRL_OFFS, {27'h0, p});
        store_program_memory_instr(k, {1'h0, pg, 7'($urandom)}, 16'($urandom));
    endtask
    task automatic lock_set(input logic [5:0] v, input logic [5:0] e);
        wr(`SPF_CTRL_OFFS, {27'h0, `SPF_PAT_LKS});
        store_program_memory_instr(1, 16'($urandom), {10'($urandom), v});
        rd(`SPF_LOCK_OFFS, 32'h3F, {26'h0, e});
    endtask
    task automatic wait_done();
        do
            @(posedge sys_clk);
        while (fl_done !== 1'h1);
        @(posedge sys_clk);
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
    endtask

    // result monitor: each result takes the oldest note of its kind
    always @(posedge sys_clk)
    begin
        if (psel && penable && pready)
        begin
            nb = (apb_q.size() == 0);
            if (!nb)
                a = apb_q.pop_front();
            cmp_note("apb", nb, a[32:0], {pslverr, prdata & a[64:33]});
        end
        if (fl_buf_we)
        begin
            nb = (buf_q.size() == 0);
            if (!nb)
                b = buf_q.pop_front();
            cmp_note("buffer", nb, {11'h0, b}, {11'h0, fl_buf_word, fl_buf_data});
            cmp_lvl("small_fill", !self_prog_fuse, sm_we);
        end
        if (fl_erase || fl_write)
        begin
            nb = (op_q.size() == 0);
            if (!nb)
                o = op_q.pop_front();
            cmp_note("array op", nb, {23'h0, o}, {23'h0, fl_write, fl_erase, fl_page});
        end
    end

    // watchdog
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        fail_count++;
        end_of_test();
    end

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        spf_word_t z, d;
        void'($urandom(32'h72785C10));
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        rd(`SPF_CTRL_OFFS, 32'hFF, 32'h0);
        rd(`SPF_LOCK_OFFS, 32'hFF, 32'hFF);
        apb(1'h1, 12'h00C, 32'hFFFF_FFFF, 32'h0, 1'h1);
        for (int k = 1; k <= 4; k++)
        begin
            z = 16'($urandom);
            d = 16'($urandom);
            wr(`SPF_CTRL_OFFS, {27'h0, `SPF_PAT_FILL});
            buf_q.push_back({z[6:1], d});
            store_program_memory_instr(k, z, d);
            rd(`SPF_CTRL_OFFS, 32'h1F, 32'h0);
        end
        cmd(`SPF_PAT_FILL, 5, 8'h00);
        rd(`SPF_CTRL_OFFS, 32'h1F, 32'h0);
        foreach (bad[i])
        begin
            cmd(bad[i], 1, 8'h00);
            rd(`SPF_CTRL_OFFS, 32'h1F, 32'h0);
        end
        busy_cycles <= 8'h28;
        op_q.push_back({2'h1, 8'h10});
        cmd(`SPF_PAT_ERS, 2, 8'h10);
        @(posedge sys_clk);
        cmp_lvl("cpu_stall", 1'h0, cpu_stall);
        rd(`SPF_CTRL_OFFS, 32'h43, 32'h43);
        wait_done();
        rd(`SPF_CTRL_OFFS, 32'h7F, 32'h40);
        cmd(`SPF_PAT_RRE, 1, 8'h00);
        rd(`SPF_CTRL_OFFS, 32'hFF, 32'h0);
        busy_cycles <= 8'h06;
        op_q.push_back({2'h2, 8'hF0});
        cmd(`SPF_PAT_WRT, 4, 8'hF0);
        @(posedge sys_clk);
        cmp_lvl("cpu_stall", 1'h1, cpu_stall);
        rd(`SPF_STAT_OFFS, 32'hF, 32'h3);
        wait_done();
        cmp_lvl("cpu_stall", 1'h0, cpu_stall);
        rd(`SPF_CTRL_OFFS, 32'h1F, 32'h0);
        lock_set(6'h3B, 6'h3B);
        cmd(`SPF_PAT_ERS, 1, 8'h10);
        rd(`SPF_CTRL_OFFS, 32'h1F, 32'h0);
        lock_set(6'h3F, 6'h3B);
        lock_set(6'h33, 6'h33);
        exec_in_boot <= 1'h1;
        lpm_zptr <= 16'h0800;
        settle();
        cmp_lvl("lpm_allowed", 1'h0, lpm_allowed);
        exec_in_boot <= 1'h0;
        vec_in_boot <= 1'h1;
        settle();
        cmp_lvl("irq_suppress", 1'h1, irq_suppress);
        lock_set(6'h03, 6'h03);
        vec_in_boot <= 1'h0;
        lpm_zptr <= 16'h7800;
        settle();
        cmp_lvl("lpm_allowed", 1'h0, lpm_allowed);
        exec_in_boot <= 1'h1;
        settle();
        cmp_lvl("irq_suppress", 1'h1, irq_suppress);
        cmd(`SPF_PAT_WRT, 1, 8'hF0);
        rd(`SPF_CTRL_OFFS, 32'h1F, 32'h0);
        lock_set(6'h02, 6'h02);
        cmp_lvl("ext_prog_block", 1'h1, ext_prog_block);
        cmp_lvl("fuse_lock", 1'h1, fuse_lock);
        cmp_lvl("ext_verify_block", 1'h0, ext_verify_block);
        lock_set(6'h00, 6'h00);
        cmp_lvl("ext_verify_block", 1'h1, ext_verify_block);
        cmp_lvl("boot_lock_frozen", 1'h1, boot_lock_frozen);
        chip_erase <= 1'h1;
        @(posedge sys_clk);
        chip_erase <= 1'h0;
        rd(`SPF_LOCK_OFFS, 32'hFF, 32'hFF);
        cmp_lvl("ext_prog_block", 1'h0, ext_prog_block);
        lock_set(6'h37, 6'h37);
        lpm_zptr <= 16'h0800;
        settle();
        cmp_lvl("lpm_allowed", 1'h0, lpm_allowed);
        self_prog_fuse <= 1'h1;
        z = 16'($urandom);
        d = 16'($urandom);
        wr(`SPF_CTRL_OFFS, {27'h0, `SPF_PAT_FILL});
        buf_q.push_back({z[6:1], d});
        store_program_memory_instr(1, z, d);
        settle();
        end_of_test();
    end
endmodule
`default_nettype wire
